// ===== core/ptm_consts.vh
// Constants for the periodic timer: register map, fields, modes, counter limits and bus response codes.
`ifndef PTM_CONSTS_VH
`define PTM_CONSTS_VH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define PTM_ADDR_CTRL0 4'h0
`define PTM_ADDR_CTRL1 4'h4
`define PTM_ADDR_CNT 4'h8
`define PTM_ADDR_CMPA 4'hc
`define PTM_ADDR_CMPP_LO 4'h0
`define PTM_ADDR_CMPP_HI 4'h4
`define PTM_ADDR_FLAGS 4'h8
`define PTM_PAGE_MAIN 1'b0
`define PTM_PAGE_PER 1'b1
// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define PTM_CTRL0_ON 3
`define PTM_C1_CCLR 0
`define PTM_C1_CAPTS 1
`define PTM_C1_POL 2
`define PTM_C1_OC 3
`define PTM_FLAG_A 0
`define PTM_FLAG_P 1
`define PTM_MODE_CMP 2'h0
`define PTM_MODE_CAP 2'h1
`define PTM_MODE_PWM 2'h2
`define PTM_MODE_TMR 2'h3
`define PTM_IO_00 2'h0
`define PTM_IO_01 2'h1
`define PTM_IO_10 2'h2
`define PTM_IO_11 2'h3
`define PTM_CNT_MAX 10'h3ff
`define PTM_CNT_ZERO 10'h000
`define PTM_CNT_ONE 10'h001
`define PTM_RESP_OKAY 2'h0
`define PTM_RESP_SLVERR 2'h2
`endif

// ===== core/ptm_timer.v
// Periodic 10-bit timer with compare, PWM, single pulse and capture modes behind AXI4-Lite.
// Summary of operation
// RULE1: Mode 00 is compare-match output; counter clears by overflow, A or P match.
// RULE2: Clear select low clears on P match or overflow when P is zero; both flags.
// RULE3: Clear select high clears on A match; only flag A ever raised.
// RULE4: Compare A zero in compare mode overflows at 3FF, no flag A.
// RULE5: Compare mode output pin changes only on comparator A match.
// RULE6: A match drives pin high, low or toggles per output action; 00 no change. Here 01 drives low and 10 high, 11 toggles.
// RULE7: Counter on rising edge loads pin with initial level.
// RULE8: Mode 11 behaves as compare mode but does not drive the pin.
// RULE9: Mode 10 PWM ignores clear select; P sets period, A duty; both flags.
// RULE10: Compare P 1..1023 gives that period; 0 gives 1024 counts.
// RULE11: Duty at or above period gives 100% active output.
// RULE12: PWM initial level picks active sense, action enables or forces, polarity inverts.
// RULE13: PWM counting and matching continue while output is forced.
// RULE14: Software sets mode 10 and action 11 for single pulse, unchanged.
// RULE15: Single pulse starts on counter on rise, by software or external pin edge.
// RULE16: Single pulse A match clears counter on, ends pulse, raises flag.
// RULE17: Single pulse counter resets only on counter on rise; P and clear ignored.
// RULE18: Mode 01 captures from chosen pin with edge from output action.
// RULE19: Capture edge copies counter into compare A, raises flag; counter keeps running.
// RULE20: Capture mode P match zeroes counter and raises flag; P zero gives full count.
// RULE21: Capture action 11 disables capture while counter runs.
// RULE22: Compare P split into low byte 7..0 and high register 9..8, rest zero.
// RULE23: Counter on rise zeroes counter; fall stops and keeps residual count.
// RULE24: Capture edge: 00 rising, 01 falling, 10 both, 11 disabled.
// RULE25: PWM action 00 inactive, 01 active, 10 waveform, 11 single pulse.
// RULE26: Flags stay set until software clears; a new event wins over the clear.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`include "ptm_consts.vh"
module ptm_timer (
  input wire aclk,
  input wire aresetn,
  input wire [5:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_clock_pin,
  input wire capture_input_pin,
  output reg timer_out_q
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg counter_on_q;
  reg pause_q;
  reg [1:0] mode_q;
  reg [1:0] action_q;
  reg initial_level_q;
  reg polarity_invert_q;
  reg capture_source_select_q;
  reg clear_select_q;
  reg [9:0] compare_a_q;
  reg [9:0] compare_p_q;
  reg [9:0] count_q;
  reg match_a_flag_q;
  reg match_p_flag_q;
  reg pin_level_q;
  reg ext_prev_q;
  reg cap_prev_q;
  reg [5:0] aw_addr_q;
  reg aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_have_q;
  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Bit 5 picks the page, bits 3:0 the word within it.
  function [2:0] reg_sel;
    input [5:0] addr;
    begin
      if (addr[1:0] != 2'h0)
        reg_sel = 3'h7;
      else if (addr[5] == `PTM_PAGE_MAIN && addr[4] == 1'b0) begin
        case (addr[3:0])
          `PTM_ADDR_CTRL0: reg_sel = 3'h0;
          `PTM_ADDR_CTRL1: reg_sel = 3'h1;
          `PTM_ADDR_CNT: reg_sel = 3'h2;
          `PTM_ADDR_CMPA: reg_sel = 3'h3;
          default: reg_sel = 3'h7;
        endcase
      end else if (addr[5] == `PTM_PAGE_PER && addr[4] == 1'b0) begin
        case (addr[3:0])
          `PTM_ADDR_CMPP_LO: reg_sel = 3'h4;
          `PTM_ADDR_CMPP_HI: reg_sel = 3'h5;
          `PTM_ADDR_FLAGS: reg_sel = 3'h6;
          default: reg_sel = 3'h7;
        endcase
      end else
        reg_sel = 3'h7;
    end
  endfunction

  function edge_hit;
    input [1:0] sel;
    input prev;
    input cur;
    begin
      case (sel)
        `PTM_IO_00: edge_hit = ~prev & cur;
        `PTM_IO_01: edge_hit = prev & ~cur;
        `PTM_IO_10: edge_hit = prev ^ cur;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction
  // ----------------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------------
  wire [5:0] wr_addr = s_axi_awvalid && !aw_have_q ? s_axi_awaddr : aw_addr_q;
  wire [31:0] wr_data = s_axi_wvalid && !w_have_q ? s_axi_wdata : w_data_q;
  wire [3:0] wr_strb = s_axi_wvalid && !w_have_q ? s_axi_wstrb : w_strb_q;
  wire aw_ok = aw_have_q || (s_axi_awvalid && s_axi_awready);
  wire w_ok = w_have_q || (s_axi_wvalid && s_axi_wready);
  wire wr_go = aw_ok && w_ok && !s_axi_bvalid;
  wire [2:0] wr_sel = reg_sel(wr_addr);
  wire wr_b0 = wr_go && wr_strb[0];
  wire wr_ctrl0 = wr_b0 && wr_sel == 3'h0;
  wire wr_ctrl1 = wr_b0 && wr_sel == 3'h1;
  wire wr_cmpa_lo = wr_b0 && wr_sel == 3'h3;
  wire wr_cmpa_hi = wr_go && wr_strb[1] && wr_sel == 3'h3;
  wire wr_flags = wr_b0 && wr_sel == 3'h6;
  // ----------------------------------------------------------------------
  // Counter core
  // ----------------------------------------------------------------------
  wire on_next = wr_ctrl0 ? wr_data[`PTM_CTRL0_ON] : counter_on_q;
  wire is_pwm = mode_q == `PTM_MODE_PWM;
  wire single = is_pwm && action_q == `PTM_IO_11;
  // The external pin arms a single pulse on its rising edge.
  wire ext_rise = ~ext_prev_q & ext_clock_pin;
  wire sp_trig = single && !counter_on_q && ext_rise; // [RULE15]
  wire on_rise = (!counter_on_q && on_next) || sp_trig; // [RULE23]
  wire running = counter_on_q && !pause_q;
  wire [9:0] cnt_inc = count_q + `PTM_CNT_ONE;
  wire hit_a = running && cnt_inc == compare_a_q;
  wire hit_p = running && cnt_inc == compare_p_q;
  // A zero compare value lets the counter wrap at its maximum.
  wire wrap = running && count_q == `PTM_CNT_MAX;
  wire cmp_like = mode_q == `PTM_MODE_CMP || mode_q == `PTM_MODE_TMR; // [RULE1] [RULE8]
  // A zero compare A would otherwise match on the wrap from the maximum count.
  wire hit_a_cmp = hit_a && compare_a_q != `PTM_CNT_ZERO; // [RULE4]
  reg clr;
  reg ev_a;
  reg ev_p;
  reg sp_end;
  always @* begin
    clr = 1'b0;
    ev_a = 1'b0;
    ev_p = 1'b0;
    sp_end = 1'b0;
    if (cmp_like) begin
      if (clear_select_q) begin
        clr = hit_a || (compare_a_q == `PTM_CNT_ZERO && wrap); // [RULE3] [RULE4]
        ev_a = hit_a_cmp; // [RULE3]
      end else begin
        clr = hit_p || (compare_p_q == `PTM_CNT_ZERO && wrap); // [RULE2]
        ev_a = hit_a_cmp; // [RULE2] [RULE4]
        ev_p = hit_p; // [RULE2]
      end
    end else if (is_pwm && !single) begin
      clr = hit_p || (compare_p_q == `PTM_CNT_ZERO && wrap); // [RULE9] [RULE10] [RULE13]
      ev_a = hit_a; // [RULE9]
      ev_p = hit_p;
    end else if (single) begin
      ev_a = hit_a; // [RULE16] [RULE17]
      sp_end = hit_a;
    end else begin
      clr = hit_p || (compare_p_q == `PTM_CNT_ZERO && wrap); // [RULE20]
      ev_p = hit_p; // [RULE20]
    end
  end
  wire cap_pin = capture_source_select_q ? ext_clock_pin : capture_input_pin;
  wire cap_prev = capture_source_select_q ? ext_prev_q : cap_prev_q;
  wire cap_hit = mode_q == `PTM_MODE_CAP && counter_on_q &&
                 edge_hit(action_q, cap_prev, cap_pin); // [RULE18] [RULE21] [RULE24]
  // PWM active while count is below duty; duty at or above period stays active.
  wire [10:0] period = compare_p_q == `PTM_CNT_ZERO ? {1'b1, `PTM_CNT_ZERO} :
                       {1'b0, compare_p_q}; // [RULE10]
  wire duty_full = {1'b0, compare_a_q} >= period; // [RULE11]
  wire pwm_act = duty_full || count_q < compare_a_q;
  reg pwm_lvl;
  always @* begin
    case (action_q)
      `PTM_IO_00: pwm_lvl = 1'b0; // [RULE25]
      `PTM_IO_01: pwm_lvl = 1'b1; // [RULE25]
      `PTM_IO_10: pwm_lvl = pwm_act && counter_on_q;
      default: pwm_lvl = counter_on_q;
    endcase
  end
  wire pwm_out = (pwm_lvl ? initial_level_q : ~initial_level_q) ^ polarity_invert_q; // [RULE12]

  always @(posedge aclk) begin
    if (!aresetn) begin
      counter_on_q <= 1'b0;
      pause_q <= 1'b0;
      mode_q <= `PTM_MODE_CMP;
      action_q <= `PTM_IO_00;
      initial_level_q <= 1'b0;
      polarity_invert_q <= 1'b0;
      capture_source_select_q <= 1'b0;
      clear_select_q <= 1'b0;
      compare_a_q <= `PTM_CNT_ZERO;
      compare_p_q <= `PTM_CNT_ZERO;
      count_q <= `PTM_CNT_ZERO;
      match_a_flag_q <= 1'b0;
      match_p_flag_q <= 1'b0;
      pin_level_q <= 1'b0;
      ext_prev_q <= 1'b0;
      cap_prev_q <= 1'b0;
      timer_out_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_clock_pin;
      cap_prev_q <= capture_input_pin;
      if (wr_ctrl0)
        pause_q <= wr_data[4];
      if (wr_ctrl1) begin
        mode_q <= wr_data[7:6];
        action_q <= wr_data[5:4];
        initial_level_q <= wr_data[`PTM_C1_OC];
        polarity_invert_q <= wr_data[`PTM_C1_POL];
        capture_source_select_q <= wr_data[`PTM_C1_CAPTS];
        clear_select_q <= wr_data[`PTM_C1_CCLR];
      end
      if (wr_go && wr_sel == 3'h4 && wr_strb[0])
        compare_p_q[7:0] <= wr_data[7:0]; // [RULE22]
      if (wr_go && wr_sel == 3'h5 && wr_strb[0])
        compare_p_q[9:8] <= wr_data[1:0]; // [RULE22]
      // Hardware capture wins over a software write in the same cycle.
      if (cap_hit)
        compare_a_q <= count_q; // [RULE19]
      else begin
        if (wr_cmpa_lo)
          compare_a_q[7:0] <= wr_data[7:0];
        if (wr_cmpa_hi)
          compare_a_q[9:8] <= wr_data[9:8];
      end
      // Counter on: single pulse compare match clears it automatically.
      if (on_rise)
        counter_on_q <= 1'b1;
      else if (sp_end)
        counter_on_q <= 1'b0; // [RULE16]
      else
        counter_on_q <= on_next;
      if (on_rise)
        count_q <= `PTM_CNT_ZERO; // [RULE23] [RULE17]
      else if (clr)
        count_q <= `PTM_CNT_ZERO;
      else if (running && !sp_end)
        count_q <= cnt_inc; // [RULE19]
      // Flags: a new event wins over a clear written in the same cycle.
      match_a_flag_q <= ev_a || cap_hit ||
                        (match_a_flag_q && !(wr_flags && wr_data[`PTM_FLAG_A])); // [RULE26]
      match_p_flag_q <= ev_p ||
                        (match_p_flag_q && !(wr_flags && wr_data[`PTM_FLAG_P])); // [RULE26]
      if (on_rise)
        pin_level_q <= initial_level_q; // [RULE7]
      else if (mode_q == `PTM_MODE_CMP && ev_a) begin // [RULE5]
        case (action_q)
          `PTM_IO_01: pin_level_q <= 1'b0; // [RULE6]
          `PTM_IO_10: pin_level_q <= 1'b1; // [RULE6]
          `PTM_IO_11: pin_level_q <= ~pin_level_q; // [RULE6]
          default: pin_level_q <= pin_level_q;
        endcase
      end
      case (mode_q)
        `PTM_MODE_CMP: timer_out_q <= pin_level_q ^ polarity_invert_q;
        `PTM_MODE_PWM: timer_out_q <= pwm_out;
        default: timer_out_q <= 1'b0; // [RULE8]
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  reg [31:0] rd_word;
  always @* begin
    case (reg_sel(s_axi_araddr))
      3'h0: rd_word = {27'h0, pause_q, counter_on_q, 3'h0};
      3'h1: rd_word = {24'h0, mode_q, action_q, initial_level_q, polarity_invert_q,
                       capture_source_select_q, clear_select_q};
      3'h2: rd_word = {22'h0, count_q};
      3'h3: rd_word = {22'h0, compare_a_q};
      3'h4: rd_word = {24'h0, compare_p_q[7:0]};
      3'h5: rd_word = {30'h0, compare_p_q[9:8]}; // [RULE22]
      3'h6: rd_word = {30'h0, match_p_flag_q, match_a_flag_q};
      default: rd_word = 32'h0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PTM_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PTM_RESP_OKAY;
      s_axi_rdata <= 32'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 6'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= !wr_go;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= !wr_go;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go)
        w_have_q <= 1'b0;
      s_axi_awready <= !s_axi_awready && !aw_have_q && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !s_axi_wready && !w_have_q && s_axi_wvalid && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_sel == 3'h7 ? `PTM_RESP_SLVERR : `PTM_RESP_OKAY;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= reg_sel(s_axi_araddr) == 3'h7 ? `PTM_RESP_SLVERR : `PTM_RESP_OKAY;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ptm_timer

// ===== bench/ptm_timer_assertions.sv
// Concurrent checks on the bus handshakes of the periodic timer.
module ptm_timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_out_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // Handshake properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held longer than one cycle");
  chk_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready held longer than one cycle");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response changed before rready");
  chk_b_follows: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  chk_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after arready");
  chk_ar_blocked: assert property (s_axi_rvalid |=> !s_axi_arready)
    else $error("read address taken while a response is pending");
  chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned nonzero data");
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($rose(timer_out_q));
endmodule // ptm_timer_checker

bind ptm_timer ptm_timer_checker chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_out_q(timer_out_q));

// ===== bench/ptm_pin_partner.sv
// Model of the pins outside the timer: trigger pulse and capture square wave.
module ptm_pin_partner #(
  parameter int HALF = 30
) (
  input wire logic aclk,
  input wire logic fire,
  input wire logic wave_en,
  input wire logic src,
  output logic ext_clock_pin,
  output logic capture_input_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lvl_q;
  logic [2:0] trig_q;
  int cnt_q;
  initial begin
    lvl_q = 1'b0;
    trig_q = 3'h0;
    cnt_q = 0;
  end
  // ----------------------------------------------------------------------
  // Pin activity
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    trig_q <= fire ? 3'h7 : {trig_q[1:0], 1'b0};
    if (!wave_en) begin
      cnt_q <= 0;
      lvl_q <= 1'b0;
    end else if (cnt_q == HALF - 1) begin
      cnt_q <= 0;
      lvl_q <= !lvl_q;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  // The unchosen source rests low so that only the selected pin can capture.
  assign ext_clock_pin = src ? lvl_q : trig_q[2];
  assign capture_input_pin = src ? 1'b0 : lvl_q;
endmodule // ptm_pin_partner

// ===== bench/test_periodic_timer_modes.sv
// Self-checking testbench for the periodic timer.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %0t: got %h want %h", $time, g, e); end end
module test_periodic_timer_modes;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int H = 30;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire, wave_en, src;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, d, c0;
  logic [1:0] last_b, last_r;
  logic [9:0] p, a;
  wire awready, wready, bvalid, arready, rvalid, out, ext_pin, cap_pin;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int failures = 0, comparisons = 0, seed = 17535, cyc = 0, per, hi, i, j, k;
  ptm_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_clock_pin(ext_pin), .capture_input_pin(cap_pin),
    .timer_out_q(out));
  ptm_pin_partner #(.HALF(H)) pins (.aclk(aclk), .fire(fire), .wave_en(wave_en), .src(src),
    .ext_clock_pin(ext_pin), .capture_input_pin(cap_pin));
  // ----------------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------------
  task automatic wr(input logic [5:0] ad, input logic [31:0] dd);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= ad; wdata <= dd; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready && awvalid) begin ta = 1; awvalid <= 0; end
      if (wready && wvalid) begin tw = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (!bvalid);
    last_b = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [5:0] ad, output logic [31:0] dd);
    @(posedge aclk);
    araddr <= ad; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    dd = rdata;
    last_r = rresp;
    rready <= 0;
  endtask
  task automatic setup(input logic [7:0] c1, input logic [9:0] ca, input logic [9:0] cp);
    wr(6'h00, 32'h0); wr(6'h04, {24'h0, c1}); wr(6'h0c, {22'h0, ca});
    wr(6'h20, {24'h0, cp[7:0]}); wr(6'h24, {30'h0, cp[9:8]}); wr(6'h28, 32'h3); wr(6'h00, 32'h8);
  endtask
  task automatic meas(output int pr, output int hg);
    while (out) @(posedge aclk);
    while (!out) @(posedge aclk);
    pr = 0;
    hg = 0;
    while (out) begin hg++; pr++; @(posedge aclk); end
    while (!out) begin pr++; @(posedge aclk); end
  endtask
  task automatic hi_len(output int hg);
    while (!out) @(posedge aclk);
    hg = 0;
    while (out) begin hg++; @(posedge aclk); end
  endtask
  task automatic wait_edge(input int io);
    logic pv;
    pv = src ? ext_pin : cap_pin;
    forever begin
      @(posedge aclk);
      if ((src ? ext_pin : cap_pin) != pv && (io == 2 || (src ? ext_pin : cap_pin) == (io != 1)))
        break;
      pv = src ? ext_pin : cap_pin;
    end
  endtask
  function automatic logic [7:0] c1f(logic [1:0] m, io, logic oc, pol, cs, cc);
    return {m, io, oc, pol, cs, cc};
  endfunction
  function automatic int exp_hi(int pp, aa, logic oc, pol);
    return (oc ^ pol) ? aa : pp - aa;
  endfunction
  function automatic logic [9:0] exp_diff(int io);
    return io == 3 ? 10'h0 : (io == 2 ? 10'(H) : 10'(2 * H));
  endfunction
  task automatic test_done();
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      $display("unexpected %0t: run timed out", $time);
      test_done();
    end
  end
  initial begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; fire = 0; wave_en = 0; src = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rd(6'h24, d); `CHK(d, 32'h0)
    rd(6'h10, d); `CHK({last_r, d}, 34'h200000000)
    wr(6'h14, 32'h1); `CHK(last_b, 2'h2)
    wr(6'h24, 32'hff); rd(6'h24, d); `CHK(d, 32'h3)
    wr(6'h20, 32'h1a5); rd(6'h20, d); `CHK(d, 32'ha5)
    for (i = 0; i < 4; i++) begin
      p = 10'(6 + {$random(seed)} % 30);
      a = 10'(1 + {$random(seed)} % (p - 1));
      setup(c1f(2'h2, 2'h2, i[1], i[0], 1'b0, 1'($random(seed))), a, p);
      meas(per, hi); `CHK(per, int'(p))
      `CHK(hi, exp_hi(p, a, i[1], i[0]))
      rd(6'h28, d); `CHK(d[1:0], 2'h3)
    end
    setup(c1f(2'h2, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0), 10'd100, 10'd0);
    meas(per, hi); `CHK(per, 1024)
    setup(c1f(2'h2, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0), 10'd20, 10'd20);
    repeat (8) @(posedge aclk);
    for (k = 0; k < 50; k++) begin @(posedge aclk); `CHK(out, 1'b1) end
    for (j = 0; j < 2; j++) begin
      setup(c1f(2'h2, 2'(j), 1'b1, 1'b0, 1'b0, 1'b0), 10'd5, 10'd12);
      repeat (40) @(posedge aclk);
      `CHK(out, j[0])
      rd(6'h28, d); `CHK(d[1:0], 2'h3)
    end
    setup(c1f(2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0), 10'd9, 10'd20);
    repeat (3) @(posedge aclk);
    `CHK(out, 1'b0)
    meas(per, hi); `CHK(per, 40)
    `CHK(hi, 20)
    rd(6'h28, d); `CHK(d[1:0], 2'h3)
    for (j = 0; j < 3; j++) begin
      setup(c1f(2'h0, 2'(j), j != 2, 1'b0, 1'b0, 1'b0), 10'd4, 10'd10);
      repeat (3) @(posedge aclk);
      `CHK(out, 1'(j != 2))
      repeat (30) @(posedge aclk);
      `CHK(out, 1'(j != 1))
    end
    setup(c1f(2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1), 10'd7, 10'd3);
    meas(per, hi); `CHK(per, 14)
    rd(6'h28, d); `CHK(d[1:0], 2'h1)
    setup(c1f(2'h0, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0), 10'd0, 10'd0);
    repeat (1100) @(posedge aclk);
    rd(6'h28, d); `CHK(d[0], 1'b0)
    `CHK(out, 1'b1)
    setup(c1f(2'h3, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0), 10'd4, 10'd10);
    for (k = 0; k < 30; k++) begin @(posedge aclk); `CHK(out, 1'b0) end
    rd(6'h28, d); `CHK(d[1:0], 2'h3)
    setup(c1f(2'h2, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0), 10'd12, 10'd3);
    hi_len(hi); `CHK(hi, 12)
    rd(6'h00, d); `CHK(d[3], 1'b0)
    rd(6'h28, d); `CHK(d[0], 1'b1)
    @(posedge aclk); fire <= 1;
    @(posedge aclk); fire <= 0;
    hi_len(hi); `CHK(hi, 12)
    wr(6'h0c, 32'd200); wr(6'h00, 32'h8);
    repeat (10) @(posedge aclk);
    `CHK(out, 1'b1)
    wr(6'h00, 32'h0);
    repeat (3) @(posedge aclk);
    `CHK(out, 1'b0)
    for (j = 0; j < 4; j++) begin
      setup(c1f(2'h1, 2'(j), 1'b0, 1'b0, j[0], 1'b0), 10'd0, 10'd0);
      src <= j[0]; wave_en <= 1;
      wait_edge(j); repeat (8) @(posedge aclk); rd(6'h0c, c0);
      wait_edge(j); repeat (8) @(posedge aclk); rd(6'h0c, d);
      `CHK(d[9:0] - c0[9:0], exp_diff(j))
      rd(6'h28, d); `CHK(d[0], 1'(j != 3))
      @(posedge aclk); wave_en <= 0;
    end
    setup(c1f(2'h1, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0), 10'd0, 10'd20);
    repeat (50) @(posedge aclk);
    rd(6'h08, d); `CHK(d < 20, 1'b1)
    rd(6'h28, d); `CHK(d[1], 1'b1)
    wr(6'h00, 32'h0); rd(6'h08, c0);
    repeat (20) @(posedge aclk);
    rd(6'h08, d); `CHK(d, c0)
    wr(6'h00, 32'h8); rd(6'h08, d); `CHK(d < 8, 1'b1)
    test_done();
  end
endmodule // test_periodic_timer_modes
